// file: verilog/core_pins_pkg.sv
// register map, field layout, reset values and state types of the pin bridge
package core_pins_pkg;
    // ==========================================================
    // register byte offsets on the wishbone slave
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_MEM_ADDR  = 8'h04;
    localparam logic [7:0] REG_MEM_CMD   = 8'h08;
    localparam logic [7:0] REG_MEM_STAT  = 8'h0C;
    localparam logic [7:0] REG_XREG_CMD  = 8'h10;
    localparam logic [7:0] REG_XREG_STAT = 8'h14;
    localparam logic [7:0] REG_IRQ_STAT  = 8'h18;
    localparam logic [7:0] REG_IRQ_MASK  = 8'h1C;
    localparam logic [7:0] REG_PORT_BASE = 8'h20;
    // ==========================================================
    // field positions
    localparam int CTRL_BAUD     = 0;
    localparam int CTRL_EDGE0    = 1;
    localparam int CTRL_EDGE1    = 2;
    localparam int CTRL_SLEEP    = 3;
    localparam int MCMD_WRITE    = 8;
    localparam int MCMD_PROG     = 9;
    localparam int XCMD_ADDR_LSB = 8;
    localparam int XCMD_WRITE    = 15;
    localparam int STAT_BUSY     = 8;
    // ==========================================================
    // special function register map of the direction registers
    localparam logic [7:0] SFR_DIR_FIRST = 8'hA4;
    localparam logic [7:0] SFR_DIR_LAST  = 8'hA7;
    // ==========================================================
    // reset values
    localparam logic [7:0] DIR_RESET  = 8'hFF;
    localparam logic [7:0] OUT_RESET  = 8'h00;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [5:0] MASK_RESET = 6'h00;
    // ==========================================================
    // counts
    localparam int MEM_STROBE_CYCLES = 2;
    localparam int NUM_PORTS         = 4;
    localparam int NUM_IRQ           = 6;
    // ==========================================================
    // state types
    typedef enum logic [1:0] {
        MEM_IDLE   = 2'b00,
        MEM_SETUP  = 2'b01,
        MEM_STROBE = 2'b11,
        MEM_HOLD   = 2'b10
    } mem_state_t;
    typedef enum logic {
        X_IDLE  = 1'b0,
        X_DRIVE = 1'b1
    } xreg_state_t;
endpackage

// file: verilog/irq_lines_if.sv
// interrupt lines between the bridge and its input conditioner
`timescale 1ns/10ps
interface irq_lines_if;
    logic [5:0] line;
    logic [1:0] edge_mode;
    logic [5:0] request;
    modport sense (input line, input edge_mode, output request);
    modport ctrl  (output line, output edge_mode, input request);
endinterface

// file: verilog/irq_sense.sv
// level detection of the six external interrupt lines, falling edge detection of lines zero and one
`timescale 1ns/10ps
module irq_sense (
    input wire logic   sys_clk,
    input wire logic   rst_n,
    irq_lines_if.sense lines
);
    typedef struct packed {
        logic [1:0] prev;
        logic [5:0] req;
    } sense_state_t;

    sense_state_t st_ff;
    sense_state_t nxt_st;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // request detection
    always_comb begin
        nxt_st = st_ff;
        nxt_st.prev = lines.line[1:0];
        for (int i = 0; i < 2; i++) begin
            nxt_st.req[i] = lines.edge_mode[i] ? (st_ff.prev[i] & ~lines.line[i]) : ~lines.line[i];
        end
        nxt_st.req[5:2] = lines.line[5:2];
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff      <= '0;
            st_ff.prev <= 2'h3;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign lines.request = st_ff.req;

    // ==========================================================
    // checks
    a_level_low: assert property (!lines.edge_mode[0] && !lines.line[0] |=> lines.request[0])
        else $error("low level line zero gave no request");
    a_edge_fall: assert property (lines.edge_mode[1] && $fell(lines.line[1]) |=> lines.request[1])
        else $error("falling edge on line one gave no request");
    a_edge_quiet: assert property (lines.edge_mode[0] && $stable(lines.line[0]) |=> !lines.request[0])
        else $error("edge mode line zero requested without an edge");
    c_edge_seen: cover property (lines.edge_mode[0] && $fell(lines.line[0]));
endmodule

// file: verilog/cpu_pin_bridge.sv
// pin level interface of the microcontroller core behind a wishbone slave
`timescale 1ns/10ps
// How it works
// - the register space, except the direction registers at A4 to A7, is carried out on an external address, data and load bus for user registers.
// - the load strobe is high for exactly the cycle in which user logic captures the outgoing byte.
// - program select is low during a memory read from program space and high otherwise.
// - the read strobe is low only while a memory read is in progress.
// - the write strobe is low only while a memory write is in progress.
// - read data is sampled from its own 8-bit input bus.
// - write data is driven on its own 8-bit output bus, held through the strobe.
// - in level mode interrupts zero and one request while their line is held low.
// - in edge mode interrupts zero and one request once per falling edge.
// - each of the four ports has its own input, output and direction bus.
// - the baud doubling bit of the control register is driven out for a serial peripheral.
// - a one in a direction bit makes that port bit an input, a zero an output.
module cpu_pin_bridge #(
    parameter int STROBE_CYCLES = core_pins_pkg::MEM_STROBE_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        wb_cyc,
    input  wire logic        wb_stb,
    input  wire logic        wb_we,
    input  wire logic [7:0]  wb_adr,
    input  wire logic [3:0]  wb_sel,
    input  wire logic [31:0] wb_dat_w,
    output wire logic [31:0] wb_dat_r,
    output wire logic        wb_ack,
    output wire logic        irq,
    output wire logic        sleep_state_flag,
    output wire logic        baud_double_bit,
    input  wire logic [7:0]  mem_read_bus,
    output wire logic [7:0]  mem_write_bus,
    output wire logic        mem_bus_direction,
    output wire logic [15:0] mem_address_bus,
    output wire logic        program_select_n,
    output wire logic        mem_read_n,
    output wire logic        mem_write_n,
    input  wire logic [7:0]  xreg_read_bus,
    output wire logic [7:0]  xreg_write_bus,
    output wire logic [6:0]  xreg_address_bus,
    output wire logic        xreg_load_strobe,
    input  wire logic        ext_irq_zero,
    input  wire logic        ext_irq_one,
    input  wire logic        ext_irq_two,
    input  wire logic        ext_irq_three,
    input  wire logic        ext_irq_four,
    input  wire logic        ext_irq_five,
    output wire logic        irq_two_clear,
    output wire logic        irq_three_clear,
    input  wire logic [7:0]  port_zero_input,
    output wire logic [7:0]  port_zero_output,
    output wire logic [7:0]  port_zero_direction,
    input  wire logic [7:0]  port_one_input,
    output wire logic [7:0]  port_one_output,
    output wire logic [7:0]  port_one_direction,
    input  wire logic [7:0]  port_two_input,
    output wire logic [7:0]  port_two_output,
    output wire logic [7:0]  port_two_direction,
    input  wire logic [7:0]  port_three_input,
    output wire logic [7:0]  port_three_output,
    output wire logic [7:0]  port_three_direction
);
    typedef struct packed {
        logic                        ack;
        logic [31:0]                 rdat;
        logic [3:0]                  ctrl;
        logic [15:0]                 maddr;
        logic [7:0]                  mwdat;
        logic                        mwe;
        logic                        mprog;
        core_pins_pkg::mem_state_t   mst;
        logic [7:0]                  mcnt;
        logic [7:0]                  mrdat;
        logic                        rd_n;
        logic                        wr_n;
        logic                        psen_n;
        logic                        mdir;
        core_pins_pkg::xreg_state_t  xst;
        logic [6:0]                  xaddr;
        logic [7:0]                  xwdat;
        logic                        xwe;
        logic                        load;
        logic [7:0]                  xrdat;
        logic [5:0]                  istat;
        logic [5:0]                  imask;
        logic                        irq;
        logic                        clr2;
        logic                        clr3;
        logic [3:0][7:0]             pout;
        logic [3:0][7:0]             pdir;
    } bridge_state_t;

    bridge_state_t   st_ff;
    bridge_state_t   nxt_st;
    logic [1:0]      rst_pipe_ff;
    logic            rst_n_sync;
    logic            take;
    logic [7:0]      sfr_addr;
    logic            sfr_internal;
    logic            xcmd_go;
    logic            xcmd_ext_wr;
    logic            dir_wr;
    logic [3:0][7:0] pin;
    irq_lines_if     irq_bus ();

    // ==========================================================
    // decode helpers
    function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
        reg_hit = (adr[7:2] == off[7:2]);
    endfunction

    function automatic logic dir_sfr(input logic [7:0] a);
        dir_sfr = (a >= core_pins_pkg::SFR_DIR_FIRST) && (a <= core_pins_pkg::SFR_DIR_LAST);
    endfunction

    // ==========================================================
    // reset release
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_pipe_ff <= 2'h0;
        end else begin
            rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
        end
    end
    assign rst_n_sync = rst_pipe_ff[1];

    // ==========================================================
    // interrupt conditioner
    assign irq_bus.line      = {ext_irq_five, ext_irq_four, ext_irq_three, ext_irq_two, ext_irq_one, ext_irq_zero};
    assign irq_bus.edge_mode = {st_ff.ctrl[core_pins_pkg::CTRL_EDGE1], st_ff.ctrl[core_pins_pkg::CTRL_EDGE0]};

    irq_sense u_irq_sense (
        .sys_clk (sys_clk),
        .rst_n   (rst_n_sync),
        .lines   (irq_bus)
    );

    // ==========================================================
    // bus decode
    assign pin          = {port_three_input, port_two_input, port_one_input, port_zero_input};
    assign take         = wb_cyc & wb_stb & ~st_ff.ack;
    assign sfr_addr     = {1'b1, wb_dat_w[core_pins_pkg::XCMD_ADDR_LSB +: 7]};
    assign sfr_internal = dir_sfr(sfr_addr);
    assign xcmd_go      = take & wb_we & reg_hit(wb_adr, core_pins_pkg::REG_XREG_CMD) & (st_ff.xst == core_pins_pkg::X_IDLE);
    assign xcmd_ext_wr  = xcmd_go & ~sfr_internal & wb_dat_w[core_pins_pkg::XCMD_WRITE];
    assign dir_wr       = xcmd_go & sfr_internal & wb_dat_w[core_pins_pkg::XCMD_WRITE];

    // ==========================================================
    // next state
    always_comb begin
        logic [31:0] rd_word;
        rd_word = 32'h0000_0000;
        nxt_st = st_ff;
        nxt_st.ack = take;
        nxt_st.clr2 = 1'b0;
        nxt_st.clr3 = 1'b0;
        nxt_st.load = 1'b0;
        // register reads
        if (reg_hit(wb_adr, core_pins_pkg::REG_CTRL)) rd_word[3:0] = st_ff.ctrl;
        if (reg_hit(wb_adr, core_pins_pkg::REG_MEM_ADDR)) rd_word[15:0] = st_ff.maddr;
        if (reg_hit(wb_adr, core_pins_pkg::REG_MEM_STAT)) begin
            rd_word[7:0] = st_ff.mrdat;
            rd_word[core_pins_pkg::STAT_BUSY] = (st_ff.mst != core_pins_pkg::MEM_IDLE);
        end
        if (reg_hit(wb_adr, core_pins_pkg::REG_XREG_STAT)) begin
            rd_word[7:0] = st_ff.xrdat;
            rd_word[core_pins_pkg::STAT_BUSY] = (st_ff.xst != core_pins_pkg::X_IDLE);
        end
        if (reg_hit(wb_adr, core_pins_pkg::REG_IRQ_STAT)) rd_word[5:0] = st_ff.istat;
        if (reg_hit(wb_adr, core_pins_pkg::REG_IRQ_MASK)) rd_word[5:0] = st_ff.imask;
        for (int p = 0; p < core_pins_pkg::NUM_PORTS; p++) begin
            if (reg_hit(wb_adr, core_pins_pkg::REG_PORT_BASE + 8'(4 * p))) begin
                rd_word[23:0] = {st_ff.pdir[p], st_ff.pout[p], pin[p]};
            end
        end
        nxt_st.rdat = (take & ~wb_we) ? rd_word : 32'h0000_0000;
        // register writes
        if (take & wb_we) begin
            if (reg_hit(wb_adr, core_pins_pkg::REG_CTRL) & wb_sel[0]) nxt_st.ctrl = wb_dat_w[3:0];
            if (reg_hit(wb_adr, core_pins_pkg::REG_MEM_ADDR)) begin
                if (wb_sel[0]) nxt_st.maddr[7:0] = wb_dat_w[7:0];
                if (wb_sel[1]) nxt_st.maddr[15:8] = wb_dat_w[15:8];
            end
            if (reg_hit(wb_adr, core_pins_pkg::REG_IRQ_MASK) & wb_sel[0]) nxt_st.imask = wb_dat_w[5:0];
            for (int p = 0; p < core_pins_pkg::NUM_PORTS; p++) begin
                if (reg_hit(wb_adr, core_pins_pkg::REG_PORT_BASE + 8'(4 * p))) begin
                    if (wb_sel[1]) nxt_st.pout[p] = wb_dat_w[15:8];
                    if (wb_sel[2]) nxt_st.pdir[p] = wb_dat_w[23:16];
                end
            end
        end
        // sticky status, read clears, new event wins
        nxt_st.istat = st_ff.istat;
        if (take & ~wb_we & reg_hit(wb_adr, core_pins_pkg::REG_IRQ_STAT)) begin
            nxt_st.istat = 6'h00;
            nxt_st.clr2 = st_ff.istat[2];
            nxt_st.clr3 = st_ff.istat[3];
        end
        nxt_st.istat = nxt_st.istat | irq_bus.request;
        nxt_st.irq = |(nxt_st.istat & nxt_st.imask);
        // external memory access
        unique case (st_ff.mst)
            core_pins_pkg::MEM_IDLE: begin
                if (take & wb_we & reg_hit(wb_adr, core_pins_pkg::REG_MEM_CMD)) begin
                    nxt_st.mst = core_pins_pkg::MEM_SETUP;
                    nxt_st.mwdat = wb_dat_w[7:0];
                    nxt_st.mwe = wb_dat_w[core_pins_pkg::MCMD_WRITE];
                    nxt_st.mprog = wb_dat_w[core_pins_pkg::MCMD_PROG];
                    nxt_st.psen_n = ~(wb_dat_w[core_pins_pkg::MCMD_PROG] & ~wb_dat_w[core_pins_pkg::MCMD_WRITE]);
                    nxt_st.mdir = ~wb_dat_w[core_pins_pkg::MCMD_WRITE];
                end
            end
            core_pins_pkg::MEM_SETUP: begin
                nxt_st.mst = core_pins_pkg::MEM_STROBE;
                nxt_st.mcnt = 8'(STROBE_CYCLES - 1);
                nxt_st.rd_n = st_ff.mwe;
                nxt_st.wr_n = ~st_ff.mwe;
            end
            core_pins_pkg::MEM_STROBE: begin
                if (st_ff.mcnt == 8'h00) begin
                    nxt_st.mst = core_pins_pkg::MEM_HOLD;
                    nxt_st.rd_n = 1'b1;
                    nxt_st.wr_n = 1'b1;
                    if (!st_ff.mwe) nxt_st.mrdat = mem_read_bus;
                end else begin
                    nxt_st.mcnt = st_ff.mcnt - 8'h01;
                end
            end
            core_pins_pkg::MEM_HOLD: begin
                nxt_st.mst = core_pins_pkg::MEM_IDLE;
                nxt_st.psen_n = 1'b1;
                nxt_st.mdir = 1'b1;
            end
        endcase
        // external register access
        unique case (st_ff.xst)
            core_pins_pkg::X_IDLE: begin
                if (xcmd_go & sfr_internal) begin
                    if (dir_wr) nxt_st.pdir[sfr_addr[1:0]] = wb_dat_w[7:0];
                    else nxt_st.xrdat = st_ff.pdir[sfr_addr[1:0]];
                end else if (xcmd_go) begin
                    nxt_st.xst = core_pins_pkg::X_DRIVE;
                    nxt_st.xaddr = wb_dat_w[core_pins_pkg::XCMD_ADDR_LSB +: 7];
                    nxt_st.xwdat = wb_dat_w[7:0];
                    nxt_st.xwe = wb_dat_w[core_pins_pkg::XCMD_WRITE];
                    nxt_st.load = xcmd_ext_wr;
                end
            end
            core_pins_pkg::X_DRIVE: begin
                nxt_st.xst = core_pins_pkg::X_IDLE;
                if (!st_ff.xwe) nxt_st.xrdat = xreg_read_bus;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            st_ff        <= '0;
            st_ff.ctrl   <= core_pins_pkg::CTRL_RESET;
            st_ff.imask  <= core_pins_pkg::MASK_RESET;
            st_ff.rd_n   <= 1'b1;
            st_ff.wr_n   <= 1'b1;
            st_ff.psen_n <= 1'b1;
            st_ff.mdir   <= 1'b1;
            st_ff.pout   <= {core_pins_pkg::NUM_PORTS{core_pins_pkg::OUT_RESET}};
            st_ff.pdir   <= {core_pins_pkg::NUM_PORTS{core_pins_pkg::DIR_RESET}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // outputs
    assign wb_dat_r             = st_ff.rdat;
    assign wb_ack               = st_ff.ack;
    assign irq                  = st_ff.irq;
    assign sleep_state_flag     = st_ff.ctrl[core_pins_pkg::CTRL_SLEEP];
    assign baud_double_bit      = st_ff.ctrl[core_pins_pkg::CTRL_BAUD];
    assign mem_write_bus        = st_ff.mwdat;
    assign mem_bus_direction    = st_ff.mdir;
    assign mem_address_bus      = st_ff.maddr;
    assign program_select_n     = st_ff.psen_n;
    assign mem_read_n           = st_ff.rd_n;
    assign mem_write_n          = st_ff.wr_n;
    assign xreg_write_bus       = st_ff.xwdat;
    assign xreg_address_bus     = st_ff.xaddr;
    assign xreg_load_strobe     = st_ff.load;
    assign irq_two_clear        = st_ff.clr2;
    assign irq_three_clear      = st_ff.clr3;
    assign port_zero_output     = st_ff.pout[0];
    assign port_zero_direction  = st_ff.pdir[0];
    assign port_one_output      = st_ff.pout[1];
    assign port_one_direction   = st_ff.pdir[1];
    assign port_two_output      = st_ff.pout[2];
    assign port_two_direction   = st_ff.pdir[2];
    assign port_three_output    = st_ff.pout[3];
    assign port_three_direction = st_ff.pdir[3];

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n_sync);

    a_xreg_addr_out: assert property (xcmd_go && !sfr_internal |=> xreg_address_bus == $past(sfr_addr[6:0]))
        else $error("external register address not driven");
    a_load_follows: assert property (xcmd_ext_wr |=> xreg_load_strobe ##1 !xreg_load_strobe)
        else $error("load strobe not a single cycle after a write");
    a_load_cause: assert property (xreg_load_strobe |-> $past(xcmd_ext_wr))
        else $error("load strobe without an external register write");
    a_psen_program: assert property (!program_select_n |-> st_ff.mst != core_pins_pkg::MEM_IDLE && st_ff.mprog)
        else $error("program select low outside a program access");
    a_read_strobe: assert property (!mem_read_n |-> st_ff.mst == core_pins_pkg::MEM_STROBE && !st_ff.mwe)
        else $error("read strobe low outside a read");
    a_write_strobe: assert property (!mem_write_n |-> !mem_bus_direction && st_ff.mwe)
        else $error("write strobe low outside a write");
    a_read_capture: assert property ($rose(mem_read_n) |-> st_ff.mrdat == $past(mem_read_bus))
        else $error("read data not sampled at strobe end");
    a_write_stable: assert property (!mem_write_n |-> $stable(mem_write_bus))
        else $error("write data moved during the strobe");
    a_baud_follows: assert property (take && wb_we && reg_hit(wb_adr, core_pins_pkg::REG_CTRL) && wb_sel[0]
        |=> baud_double_bit == $past(wb_dat_w[0]))
        else $error("baud bit does not follow control write");
    a_dir_internal: assert property (dir_wr |=> port_zero_direction == $past(wb_dat_w[7:0])
        || $past(sfr_addr[1:0]) != 2'h0)
        else $error("direction register write lost");
    a_xreg_read: assert property (st_ff.xst == core_pins_pkg::X_DRIVE && !st_ff.xwe
        |=> st_ff.xrdat == $past(xreg_read_bus))
        else $error("external register read result wrong");

    c_mem_read: cover property ($rose(mem_read_n) && mem_bus_direction);
    c_mem_write: cover property ($rose(mem_write_n));
    c_xreg_load: cover property (xreg_load_strobe);
    c_irq_raise: cover property ($rose(irq));
endmodule

// file: tb/far_side_model.sv
// far side model: external memory and user register bank
`timescale 1ns/10ps
module far_side_model (
    input  wire logic        sys_clk,
    input  wire logic [15:0] mem_address_bus,
    input  wire logic [7:0]  mem_write_bus,
    input  wire logic        mem_read_n,
    input  wire logic        mem_write_n,
    output logic      [7:0]  mem_read_bus,
    input  wire logic [7:0]  xreg_write_bus,
    input  wire logic [6:0]  xreg_address_bus,
    input  wire logic        xreg_load_strobe,
    output logic      [7:0]  xreg_read_bus
);
    logic [7:0] mem_ff [256];
    logic [7:0] xr_ff [128];
    // ==========================================================
    // memory drives stored data only while the read strobe is low, a clock-toggled A5 pattern otherwise
    assign mem_read_bus  = mem_read_n ? (8'hA5 ^ {8{sys_clk}}) : mem_ff[mem_address_bus[7:0]];
    assign xreg_read_bus = xr_ff[xreg_address_bus];
    always_ff @(posedge sys_clk) begin
        if (!mem_write_n) mem_ff[mem_address_bus[7:0]] <= mem_write_bus;
        if (xreg_load_strobe) xr_ff[xreg_address_bus] <= xreg_write_bus;
    end
endmodule

// file: tb/cpu_pin_bridge_bench.sv
// self-checking bench of the pin bridge
`timescale 1ns/10ps
module cpu_pin_bridge_bench;
    localparam int SC = 3;
    logic sys_clk = 1'h0, resetn = 1'h0, wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0, wb_ack, irq;
    logic ext_irq_zero = 1'h1, ext_irq_one = 1'h1, ext_irq_two = 1'h0, ext_irq_three = 1'h0;
    logic ext_irq_four = 1'h0, ext_irq_five = 1'h0, sleep_state_flag, baud_double_bit, mem_bus_direction;
    logic program_select_n, mem_read_n, mem_write_n, xreg_load_strobe, irq_two_clear, irq_three_clear;
    logic [7:0] wb_adr = 8'h00, d, a, mem_read_bus, xreg_read_bus, mem_write_bus, xreg_write_bus;
    logic [7:0] port_zero_input = 8'h00, port_one_input = 8'h00, port_two_input = 8'h00;
    logic [7:0] port_three_input = 8'h00, port_zero_output, port_one_output, port_two_output;
    logic [7:0] port_three_output, port_zero_direction, port_one_direction, port_two_direction;
    logic [7:0] port_three_direction;
    logic [3:0] wb_sel = 4'hF;
    logic [31:0] wb_dat_w = 32'h0000_0000, wb_dat_r, q;
    logic [15:0] mem_address_bus;
    logic [6:0] xreg_address_bus;
    int err_total = 0, checks_done = 0, ld = 0, rs = 0, ws = 0, ps = 0, cl = 0, t, s[5];
    cpu_pin_bridge #(.STROBE_CYCLES(SC)) cpu_pin_bridge_inst (.*);
    far_side_model far_side_model_inst (.*);
    initial forever #25 sys_clk = ~sys_clk;
    // ==========================================================
    // pin activity counters
    always @(posedge sys_clk) begin
        ld <= ld + int'(xreg_load_strobe === 1'b1);
        rs <= rs + int'(mem_read_n === 1'b0);
        ws <= ws + int'(mem_write_n === 1'b0);
        ps <= ps + int'(program_select_n === 1'b0);
        cl <= cl + int'(irq_two_clear === 1'b1) + int'(irq_three_clear === 1'b1);
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] dw);
        int n;
        n = 0;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} <= {2'h3, w, ad, dw};
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        q = wb_dat_r;
        if (wb_ack !== 1'b1) begin
            err_total++;
            stop_test();
        end
        {wb_cyc, wb_stb} <= 2'h0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] ad);
        wb(1'h0, ad, 32'h0000_0000);
    endtask
    task automatic mem_op(input logic [31:0] c);
        wb(1'h1, core_pins_pkg::REG_MEM_CMD, c);
        for (int n = 0; n < 20; n++) begin
            rd(core_pins_pkg::REG_MEM_STAT);
            if (q[core_pins_pkg::STAT_BUSY] === 1'b0) return;
        end
        err_total++;
        stop_test();
    endtask
    function automatic logic [7:0] pick(input logic [31:0] v, input int p);
        return v[8 * p +: 8];
    endfunction
    initial begin
        void'($urandom(60));
        repeat (5) @(posedge sys_clk);
        resetn <= 1'h1;
        repeat (3) @(posedge sys_clk);
        chk(port_zero_direction, 8'hFF);
        chk({4'h0, mem_read_n, mem_write_n, program_select_n, mem_bus_direction}, 8'h0F);
        wb(1'h1, core_pins_pkg::REG_CTRL, 32'h0000_0009);
        chk({6'h00, baud_double_bit, sleep_state_flag}, 8'h03);
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            a = 8'($urandom);
            s = '{ld, rs, ws, ps, cl};
            wb(1'h1, core_pins_pkg::REG_MEM_ADDR, {16'h0000, a, a});
            mem_op({22'h00_0000, i[0], 1'b1, d});
            mem_op({22'h00_0000, i[0], 1'b0, 8'h00});
            chk(q[7:0], d);
            chk(8'(rs - s[1]), 8'(SC));
            chk(8'(ws - s[2]), 8'(SC));
            chk({7'h00, ps != s[3]}, {7'h00, i[0]});
        end
        t = ld;
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            a = 8'($urandom) & 8'h7B;
            s = '{ld, rs, ws, ps, cl};
            wb(1'h1, core_pins_pkg::REG_XREG_CMD, {16'h0000, 1'b1, a[6:0], d});
            chk(8'(ld - s[0]), 8'h01);
            wb(1'h1, core_pins_pkg::REG_XREG_CMD, {16'h0000, 1'b0, a[6:0], 8'h00});
            rd(core_pins_pkg::REG_XREG_STAT);
            chk(q[7:0], d);
        end
        d = 8'($urandom);
        wb(1'h1, core_pins_pkg::REG_XREG_CMD, {16'h0000, 8'hA4, d});
        chk(port_zero_direction, d);
        chk(8'(ld - t), 8'h04);
        {port_three_input, port_two_input, port_one_input, port_zero_input} <= $urandom;
        for (int p = 0; p < 4; p++) begin
            d = 8'($urandom);
            a = 8'($urandom);
            wb(1'h1, 8'(core_pins_pkg::REG_PORT_BASE + 4 * p), {8'h00, d, a, 8'h00});
            rd(8'(core_pins_pkg::REG_PORT_BASE + 4 * p));
            chk(q[23:16], d);
            chk(q[15:8], a);
            chk(q[7:0], pick({port_three_input, port_two_input, port_one_input, port_zero_input}, p));
        end
        chk(port_three_output, a);
        chk(port_three_direction, d);
        wb(1'h1, core_pins_pkg::REG_IRQ_MASK, 32'h0000_0004);
        rd(core_pins_pkg::REG_IRQ_STAT);
        ext_irq_three <= 1'h1;
        repeat (4) @(posedge sys_clk);
        chk({7'h00, irq}, 8'h00);
        ext_irq_two <= 1'h1;
        repeat (4) @(posedge sys_clk);
        {ext_irq_two, ext_irq_three} <= 2'h0;
        chk({7'h00, irq}, 8'h01);
        repeat (2) @(posedge sys_clk);
        s = '{ld, rs, ws, ps, cl};
        rd(core_pins_pkg::REG_IRQ_STAT);
        chk(q[7:0], 8'h0C);
        chk(8'(cl - s[4]), 8'h02);
        rd(core_pins_pkg::REG_IRQ_STAT);
        chk({q[6:0], irq}, 8'h00);
        ext_irq_zero <= 1'h0;
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < 2; i++) begin
            rd(core_pins_pkg::REG_IRQ_STAT);
            chk(q[7:0], 8'h01);
        end
        ext_irq_zero <= 1'h1;
        wb(1'h1, core_pins_pkg::REG_CTRL, 32'h0000_0006);
        rd(core_pins_pkg::REG_IRQ_STAT);
        {ext_irq_one, ext_irq_zero} <= 2'h0;
        repeat (4) @(posedge sys_clk);
        rd(core_pins_pkg::REG_IRQ_STAT);
        chk(q[7:0], 8'h03);
        rd(core_pins_pkg::REG_IRQ_STAT);
        chk(q[7:0], 8'h00);
        stop_test();
    end
endmodule
